/* File: rtl/ppst_panel_power_timer.v */
// Panel power sequencer timing core with its register port.
// Functional notes
// - Power-up waits supply-to-data delay, on bits 28:16.
// - Power-up waits data-to-backlight delay, on bits 12:0.
// - Power-down data-off to supply-off uses off bits 28:16.
// - Power-down backlight-off delay uses off bits 12:0.
// - 100 us tick divides clock by N, field (N/2)-1.
// - The 0.1 s base divides the 100 us tick.
// - After power-down keep panel off cycle delay.
// - Power-on during cycle delay waits, then starts.
// - Zero cycle delay means none; writing zero aborts.
// - Reset reloads cycle delay 4 and counts down.
// - Write lock ignores delay and divisor writes.
// - Target writable anytime, acted on after cycle.
// - Power-on needs clock lock, pipe, port enabled.
// - Progress bits 29:28 show idle, up, down.
// - Reset warning powers panel down when enabled and it rises while fully on.
`timescale 1ns/1ps
`include "ppst_defs.vh"
module ppst_panel_power_timer (
    // Clock and reset
    input wire clock_in,
    input wire nrst_in,
    // Register port
    input wire [19:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [31:0] rdata_out,
    // Readiness and reset warning
    input wire clk_gen_locked_in,
    input wire pipe_enabled_in,
    input wire port_enabled_in,
    input wire reset_warning_in,
    // Panel controls
    output reg panel_supply_out,
    output reg panel_data_out,
    output reg panel_backlight_out
);
    // =================================================================
    // States.
    localparam [7:0] ST_OFF = 8'h01;
    localparam [7:0] ST_CYCLE = 8'h02;
    localparam [7:0] ST_UP_DATA = 8'h04;
    localparam [7:0] ST_UP_BL = 8'h08;
    localparam [7:0] ST_ON = 8'h10;
    localparam [7:0] ST_DN_BL = 8'h20;
    localparam [7:0] ST_DN_SUP = 8'h40;
    localparam [7:0] ST_DN_END = 8'h80;

    reg [1:0] rst_sync_ff;
    wire rst_n;
    reg [1:0] lock_sync_ff;
    reg [1:0] pipe_sync_ff;
    reg [1:0] port_sync_ff;
    reg [1:0] warn_sync_ff;
    reg warn_prev_ff;
    reg [31:0] on_delays_ff;
    reg [31:0] off_delays_ff;
    reg [31:0] divisor_ff;
    reg [31:0] control_ff;
    reg [7:0] state_ff;
    reg [7:0] nxt_state;
    reg rst_down_ff;
    reg load;
    reg [12:0] load_val;
    reg cyc_load;
    reg [12:0] cyc_val;
    wire fast_tick;
    wire slow_tick;
    wire step_zero;
    wire cyc_zero;
    reg step_armed_ff;
    wire step_tick;
    wire assets_ready;
    wire locked;
    wire warn_edge;
    wire cyc_abort;
    wire cycle_active;
    wire [1:0] progress;

    // =================================================================
    // Reset release and input synchronisers.
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            lock_sync_ff <= 2'h0;
            pipe_sync_ff <= 2'h0;
            port_sync_ff <= 2'h0;
            warn_sync_ff <= 2'h0;
            warn_prev_ff <= 1'b0;
        end else begin
            lock_sync_ff <= {lock_sync_ff[0], clk_gen_locked_in};
            pipe_sync_ff <= {pipe_sync_ff[0], pipe_enabled_in};
            port_sync_ff <= {port_sync_ff[0], port_enabled_in};
            warn_sync_ff <= {warn_sync_ff[0], reset_warning_in};
            warn_prev_ff <= warn_sync_ff[1];
        end
    end
    assign warn_edge = warn_sync_ff[1] & ~warn_prev_ff;
    assign assets_ready = lock_sync_ff[1] & pipe_sync_ff[1] & port_sync_ff[1];

    // =================================================================
    // Helpers.
    function wr_hit;
        input we;
        input [19:0] a;
        input [19:0] target;
        begin
            wr_hit = we && (a == target);
        end
    endfunction

    // =================================================================
    // Write lock and delay abort.
    // The lock guards the timing registers only; the control register stays
    // writable so that a power-down can always be asked for.
    assign locked = (control_ff[`PPST_KEY_HI:`PPST_KEY_LO] != `PPST_UNLOCK_KEY) &&
        (state_ff != ST_OFF) && (state_ff != ST_CYCLE);
    // A zero written to the cycle field clears a running count at once.
    assign cyc_abort = wr_hit(wr_in, addr_in, `PPST_DIVISOR_ADDR) && !locked &&
        (wdata_in[`PPST_CYC_HI:`PPST_CYC_LO] == 5'h00);
    assign cycle_active = (state_ff == ST_CYCLE) || (state_ff == ST_DN_END);

    // =================================================================
    // Registers.
    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            on_delays_ff <= `PPST_DELAYS_RESET;
            off_delays_ff <= `PPST_DELAYS_RESET;
            divisor_ff <= `PPST_DIVISOR_RESET;
            control_ff <= `PPST_CONTROL_RESET;
        end else begin
            if (wr_hit(wr_in, addr_in, `PPST_CONTROL_ADDR)) begin
                control_ff <= wdata_in & 32'hffff0003;
            end
            if (!locked) begin
                if (wr_hit(wr_in, addr_in, `PPST_ON_DELAYS_ADDR)) begin
                    on_delays_ff <= wdata_in & 32'h1fff1fff;
                end
                if (wr_hit(wr_in, addr_in, `PPST_OFF_DELAYS_ADDR)) begin
                    off_delays_ff <= wdata_in & 32'h1fff1fff;
                end
                if (wr_hit(wr_in, addr_in, `PPST_DIVISOR_ADDR)) begin
                    divisor_ff <= wdata_in & 32'hffffff1f;
                end
            end
        end
    end

    assign progress = (state_ff == ST_CYCLE && control_ff[`PPST_TARGET_BIT]) ||
        state_ff == ST_UP_DATA || state_ff == ST_UP_BL ? `PPST_PROG_UP :
        (state_ff == ST_DN_BL || state_ff == ST_DN_SUP || state_ff == ST_DN_END) ?
        `PPST_PROG_DOWN : `PPST_PROG_IDLE;

    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            rdata_out <= 32'h00000000;
        end else if (rd_in) begin
            case (addr_in)
                `PPST_STATUS_ADDR: begin
                    rdata_out <= {panel_supply_out, assets_ready, progress,
                        cycle_active, 27'h0000000};
                end
                `PPST_CONTROL_ADDR: begin
                    rdata_out <= control_ff;
                end
                `PPST_ON_DELAYS_ADDR: begin
                    rdata_out <= on_delays_ff;
                end
                `PPST_OFF_DELAYS_ADDR: begin
                    rdata_out <= off_delays_ff;
                end
                `PPST_DIVISOR_ADDR: begin
                    rdata_out <= divisor_ff;
                end
                default: begin
                    rdata_out <= 32'h00000000;
                end
            endcase
        end else begin
            rdata_out <= 32'h00000000;
        end
    end

    // =================================================================
    // Time bases and counters.
    // The step counter times the sequence steps, the cycle counter the cycle delay.
    ppst_tick_gen u_tick (
        .clock_in(clock_in),
        .rst_n_in(rst_n),
        .half_div_in(divisor_ff[`PPST_DIV_HI:`PPST_DIV_LO]),
        .fast_tick_out(fast_tick),
        .slow_tick_out(slow_tick)
    );

    // A step skips the tick already under way when it begins, so that every
    // step lasts at least its programmed number of whole ticks.
    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            step_armed_ff <= 1'b0;
        end else if (load) begin
            step_armed_ff <= 1'b0;
        end else if (fast_tick) begin
            step_armed_ff <= 1'b1;
        end
    end
    assign step_tick = fast_tick & step_armed_ff;

    ppst_down_counter u_step (
        .clock_in(clock_in),
        .rst_n_in(rst_n),
        .load_in(load),
        .value_in(load_val),
        .tick_in(step_tick),
        .clear_in(1'b0),
        .zero_out(step_zero),
        .count_out()
    );

    // The cycle counter resets to 0 and loads the default of 4 on the first clock after reset.
    reg cyc_boot_ff;
    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            cyc_boot_ff <= 1'b1;
        end else begin
            cyc_boot_ff <= 1'b0;
        end
    end

    ppst_down_counter u_cycle (
        .clock_in(clock_in),
        .rst_n_in(rst_n),
        .load_in(cyc_load),
        .value_in(cyc_val),
        .tick_in(slow_tick),
        .clear_in(cyc_abort),
        .zero_out(cyc_zero),
        .count_out()
    );

    // =================================================================
    // Sequencer.
    always @* begin
        nxt_state = state_ff;
        load = 1'b0;
        load_val = 13'h0000;
        cyc_load = 1'b0;
        cyc_val = {8'h00, divisor_ff[`PPST_CYC_HI:`PPST_CYC_LO]};
        case (state_ff)
            ST_CYCLE: begin
                if (cyc_boot_ff) begin
                    cyc_load = 1'b1;
                end else if (cyc_zero) begin
                    nxt_state = ST_OFF;
                end
            end
            ST_OFF: begin
                if (control_ff[`PPST_TARGET_BIT] && assets_ready) begin
                    nxt_state = ST_UP_DATA;
                    load = 1'b1;
                    load_val = on_delays_ff[`PPST_LONG_HI:`PPST_LONG_LO];
                end
            end
            ST_UP_DATA: begin
                if (step_zero) begin
                    nxt_state = ST_UP_BL;
                    load = 1'b1;
                    load_val = on_delays_ff[`PPST_SHORT_HI:`PPST_SHORT_LO];
                end
            end
            ST_UP_BL: begin
                if (step_zero) begin
                    nxt_state = ST_ON;
                end
            end
            ST_ON: begin
                if (!control_ff[`PPST_TARGET_BIT] || rst_down_ff) begin
                    nxt_state = ST_DN_BL;
                    load = 1'b1;
                    load_val = off_delays_ff[`PPST_SHORT_HI:`PPST_SHORT_LO];
                end
            end
            ST_DN_BL: begin
                if (step_zero) begin
                    nxt_state = ST_DN_SUP;
                    load = 1'b1;
                    load_val = off_delays_ff[`PPST_LONG_HI:`PPST_LONG_LO];
                end
            end
            ST_DN_SUP: begin
                if (step_zero) begin
                    nxt_state = ST_DN_END;
                    cyc_load = 1'b1;
                end
            end
            ST_DN_END: begin
                nxt_state = ST_CYCLE;
            end
            default: begin
                nxt_state = ST_CYCLE;
            end
        endcase
    end

    // The pins are decoded from the next state so that each moves on its step's edge.
    always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_CYCLE;
            rst_down_ff <= 1'b0;
            panel_supply_out <= 1'b0;
            panel_data_out <= 1'b0;
            panel_backlight_out <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            // The warning is latched so that it still acts once the state is read.
            if (warn_edge && control_ff[`PPST_RST_DOWN_BIT] && state_ff == ST_ON) begin
                rst_down_ff <= 1'b1;
            end else if (state_ff != ST_ON) begin
                rst_down_ff <= 1'b0;
            end
            panel_supply_out <= (nxt_state == ST_UP_DATA) || (nxt_state == ST_UP_BL) ||
                (nxt_state == ST_ON) || (nxt_state == ST_DN_BL) || (nxt_state == ST_DN_SUP);
            panel_data_out <= (nxt_state == ST_UP_BL) || (nxt_state == ST_ON) ||
                (nxt_state == ST_DN_BL);
            panel_backlight_out <= (nxt_state == ST_ON);
        end
    end
endmodule

/* File: rtl/ppst_defs.vh */
// Register offsets, field positions, reset values and timing counts of the panel power timer.
`ifndef PPST_DEFS_VH
`define PPST_DEFS_VH
// =====================================================================
// Register byte addresses
`define PPST_ADDR_W 20
`define PPST_STATUS_ADDR 20'h61200
`define PPST_CONTROL_ADDR 20'h61204
`define PPST_ON_DELAYS_ADDR 20'h61208
`define PPST_OFF_DELAYS_ADDR 20'h6120c
`define PPST_DIVISOR_ADDR 20'h61210
// =====================================================================
// Field positions
`define PPST_LONG_HI 28
`define PPST_LONG_LO 16
`define PPST_SHORT_HI 12
`define PPST_SHORT_LO 0
`define PPST_DIV_HI 31
`define PPST_DIV_LO 8
`define PPST_CYC_HI 4
`define PPST_CYC_LO 0
`define PPST_KEY_HI 31
`define PPST_KEY_LO 16
`define PPST_RST_DOWN_BIT 1
`define PPST_TARGET_BIT 0
// =====================================================================
// Reset values and constants
`define PPST_DIVISOR_RESET 32'h00270f04
`define PPST_DELAYS_RESET 32'h00000000
`define PPST_CONTROL_RESET 32'h00000000
`define PPST_UNLOCK_KEY 16'habcd
`define PPST_SLOW_DIV 11'h3e8
`define PPST_PROG_IDLE 2'h0
`define PPST_PROG_UP 2'h1
`define PPST_PROG_DOWN 2'h2
`endif

/* File: rtl/ppst_tick_gen.v */
// Reference divider producing the 100 us tick and the 0.1 s tick derived from it.
`timescale 1ns/1ps
`include "ppst_defs.vh"
module ppst_tick_gen (
    // Clock and reset
    input wire clock_in,
    input wire rst_n_in,
    // Divider setting, holds (N/2)-1
    input wire [23:0] half_div_in,
    // Ticks
    output reg fast_tick_out,
    output reg slow_tick_out
);
    reg [23:0] half_cnt_ff;
    reg phase_ff;
    reg [10:0] slow_cnt_ff;
    wire half_done;

    assign half_done = (half_cnt_ff >= half_div_in);

    // =================================================================
    // Divide by N: two halves of (half_div_in + 1) clocks each.
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            half_cnt_ff <= 24'h000000;
            phase_ff <= 1'b0;
            fast_tick_out <= 1'b0;
        end else begin
            fast_tick_out <= 1'b0;
            if (half_done) begin
                half_cnt_ff <= 24'h000000;
                phase_ff <= ~phase_ff;
                fast_tick_out <= phase_ff;
            end else begin
                half_cnt_ff <= half_cnt_ff + 24'h000001;
            end
        end
    end

    // =================================================================
    // The slow base counts fast ticks only.
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            slow_cnt_ff <= 11'h000;
            slow_tick_out <= 1'b0;
        end else begin
            slow_tick_out <= 1'b0;
            if (fast_tick_out) begin
                if (slow_cnt_ff == `PPST_SLOW_DIV - 11'h001) begin
                    slow_cnt_ff <= 11'h000;
                    slow_tick_out <= 1'b1;
                end else begin
                    slow_cnt_ff <= slow_cnt_ff + 11'h001;
                end
            end
        end
    end
endmodule

/* File: rtl/ppst_down_counter.v */
// Loadable down counter that steps once per tick and flags zero.
`timescale 1ns/1ps
module ppst_down_counter (
    // Clock and reset
    input wire clock_in,
    input wire rst_n_in,
    // Control
    input wire load_in,
    input wire [12:0] value_in,
    input wire tick_in,
    input wire clear_in,
    // Status
    output wire zero_out,
    output reg [12:0] count_out
);
    assign zero_out = (count_out == 13'h0000);

    // =================================================================
    // Load wins over a tick; clear aborts at once.
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_out <= 13'h0000;
        end else if (clear_in) begin
            count_out <= 13'h0000;
        end else if (load_in) begin
            count_out <= value_in;
        end else if (tick_in && !zero_out) begin
            count_out <= count_out - 13'h0001;
        end
    end
endmodule

/* File: test/ppst_timer_sva.sv */
// Concurrent checks on the ports of the panel power timer.
`timescale 1ns/1ps
// =====================================================================
// Checker
module ppst_timer_sva (
    // Clock and reset
    input wire clock_in,
    input wire nrst_in,
    // Register port
    input wire [19:0] addr_in,
    input wire rd_in,
    input wire [31:0] rdata_out,
    // Readiness
    input wire port_enabled_in,
    // Panel controls
    input wire panel_supply_out,
    input wire panel_data_out,
    input wire panel_backlight_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    a_bl_needs_data: assert property (panel_backlight_out |-> panel_data_out)
        else $error("Backlight on without data.");
    a_data_needs_supply: assert property (panel_data_out |-> panel_supply_out)
        else $error("Data on without supply.");
    a_rdata_one_cycle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("Read data outside its cycle.");
    a_unmapped_zero: assert property (rd_in && addr_in == 20'h61214 |=> rdata_out == 32'h0)
        else $error("Unmapped read not zero.");
    a_not_ready_off: assert property ((!port_enabled_in && !panel_supply_out) [*6]
        |=> !panel_supply_out)
        else $error("Power-up without ready assets.");
    a_bl_off_first: assert property ($fell(panel_data_out) |-> !$past(panel_backlight_out))
        else $error("Data dropped before backlight.");
    a_cycle_gap: assert property ($fell(panel_supply_out) |-> !panel_supply_out [*3])
        else $error("Supply back on too soon.");
    a_reset_quiet: assert property (disable iff (1'b0) (!nrst_in) [*2]
        |-> !panel_supply_out && !panel_data_out && !panel_backlight_out)
        else $error("Panel driven during reset.");
    c_bl_on: cover property ($rose(panel_backlight_out));
    c_supply_off: cover property ($fell(panel_supply_out));
    c_unmapped: cover property (rd_in && addr_in == 20'h61214);
endmodule
bind ppst_panel_power_timer ppst_timer_sva u_sva (.clock_in(clock_in), .nrst_in(nrst_in),
    .addr_in(addr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .port_enabled_in(port_enabled_in), .panel_supply_out(panel_supply_out),
    .panel_data_out(panel_data_out), .panel_backlight_out(panel_backlight_out));

/* File: test/ppst_panel_model.sv */
// Panel model that stamps the cycle of every supply, data and backlight change.
`timescale 1ns/1ps
// =====================================================================
// Panel
module ppst_panel_model (
    // Clock
    input wire logic clock_in,
    // Panel controls
    input wire logic supply_in,
    input wire logic data_in,
    input wire logic backlight_in,
    // Edge times in clock cycles
    output logic [31:0] t_sup_on,
    output logic [31:0] t_sup_off,
    output logic [31:0] t_dat_on,
    output logic [31:0] t_dat_off,
    output logic [31:0] t_bl_on,
    output logic [31:0] t_bl_off
);
    logic [31:0] cyc = 32'h0;
    logic [2:0] last_ff = 3'h0;
    always @(posedge clock_in) begin
        cyc <= cyc + 32'h1;
        last_ff <= {backlight_in, data_in, supply_in};
        // The panel records the order in which its controls move.
        if (supply_in && !last_ff[0]) t_sup_on <= cyc;
        if (!supply_in && last_ff[0]) t_sup_off <= cyc;
        if (data_in && !last_ff[1]) t_dat_on <= cyc;
        if (!data_in && last_ff[1]) t_dat_off <= cyc;
        if (backlight_in && !last_ff[2]) t_bl_on <= cyc;
        if (!backlight_in && last_ff[2]) t_bl_off <= cyc;
    end
endmodule

/* File: test/testbench.sv */
// Self-checking testbench of the panel power timer.
`timescale 1ns/1ps
`include "ppst_defs.vh"
// =====================================================================
// Top
module testbench;
    localparam int F = 4;
    localparam int S = 4000;
    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [19:0] addr_in = 20'h0;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic locked = 1'b0;
    logic pipe_en = 1'b0;
    logic port_en = 1'b0;
    logic warn = 1'b0;
    wire [31:0] rdata_out;
    wire [2:0] pins;
    wire [31:0] so, sf, dn, df, bn, bf;
    logic [31:0] d;
    int n_errors = 0;
    int checks_done = 0;
    always #12.5 clock_in = ~clock_in;
    ppst_panel_power_timer u_ppst_panel_power_timer (.clock_in(clock_in), .nrst_in(nrst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .clk_gen_locked_in(locked), .pipe_enabled_in(pipe_en),
        .port_enabled_in(port_en), .reset_warning_in(warn), .panel_supply_out(pins[0]),
        .panel_data_out(pins[1]), .panel_backlight_out(pins[2]));
    ppst_panel_model u_ppst_panel_model (.clock_in(clock_in), .supply_in(pins[0]),
        .data_in(pins[1]), .backlight_in(pins[2]), .t_sup_on(so), .t_sup_off(sf),
        .t_dat_on(dn), .t_dat_off(df), .t_bl_on(bn), .t_bl_off(bf));
    // =====================================================================
    // Tasks
    task end_of_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h want %h", $time, what, seen, exp);
        end
    endtask
    task check_rng(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi,
        input string what);
        checks_done++;
        if ($isunknown(v) || v < lo || v > hi) begin
            n_errors++;
            $display("BAD %0t %s took %0d not %0d..%0d", $time, what, v, lo, hi);
        end
    endtask
    task wr(input logic [19:0] a, input logic [31:0] v);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask
    task rd(input logic [19:0] a, output logic [31:0] v);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1;
        v = rdata_out;
    endtask
    task automatic wait_pin(input int k, input logic v, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge clock_in);
            #1;
            if (pins[k] === v) begin
                @(posedge clock_in);
                #1;
                return;
            end
        end
        n_errors++;
        $display("BAD %0t panel pin %0d never reached %0d", $time, k, v);
        end_of_test;
    endtask
    // =====================================================================
    // Sequence
    initial begin
        repeat (4) @(posedge clock_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        rd(`PPST_DIVISOR_ADDR, d);
        check(d, `PPST_DIVISOR_RESET, "divisor reset");
        rd(`PPST_OFF_DELAYS_ADDR, d);
        check(d, `PPST_DELAYS_RESET, "off delays reset");
        rd(`PPST_STATUS_ADDR, d);
        check(d[27], 1'b1, "cycle delay after reset");
        rd(20'h61214, d);
        check(d, 32'h0, "unmapped read");
        wr(`PPST_DIVISOR_ADDR, 32'h00000100);
        rd(`PPST_STATUS_ADDR, d);
        check(d[27], 1'b0, "cycle delay aborted");
        wr(`PPST_DIVISOR_ADDR, 32'h00000102);
        rd(`PPST_DIVISOR_ADDR, d);
        check(d, 32'h00000102, "divisor write");
        wr(`PPST_ON_DELAYS_ADDR, 32'h00030002);
        wr(`PPST_OFF_DELAYS_ADDR, 32'h00020003);
        rd(`PPST_ON_DELAYS_ADDR, d);
        check(d, 32'h00030002, "on delays");
        locked <= 1'b1;
        pipe_en <= 1'b1;
        wr(`PPST_CONTROL_ADDR, 32'h1);
        repeat (50) @(posedge clock_in);
        check(pins, 3'h0, "power-up held for port");
        port_en <= 1'b1;
        wait_pin(0, 1'b1, 100);
        rd(`PPST_STATUS_ADDR, d);
        check(d[29:28], `PPST_PROG_UP, "progress up");
        wait_pin(2, 1'b1, 200);
        check_rng(dn - so, 3 * F, 4 * F + 2, "supply to data");
        check_rng(bn - dn, 2 * F, 3 * F + 2, "data to backlight");
        rd(`PPST_STATUS_ADDR, d);
        check({d[31], d[29:28]}, 3'h4, "on and idle");
        wr(`PPST_DIVISOR_ADDR, 32'h00000105);
        rd(`PPST_DIVISOR_ADDR, d);
        check(d, 32'h00000102, "locked divisor");
        wr(`PPST_CONTROL_ADDR, 32'h0);
        wait_pin(0, 1'b0, 200);
        check_rng(df - bf, 3 * F, 4 * F + 2, "backlight off to data off");
        check_rng(sf - df, 2 * F, 3 * F + 2, "data off to supply off");
        rd(`PPST_STATUS_ADDR, d);
        check(d[27], 1'b1, "cycle delay after down");
        wr(`PPST_CONTROL_ADDR, 32'h1);
        wait_pin(0, 1'b1, 9000);
        check_rng(so - sf, S, 2 * S + 20, "held power-on");
        wait_pin(2, 1'b1, 200);
        wr(`PPST_CONTROL_ADDR, 32'h3);
        warn <= 1'b1;
        wait_pin(2, 1'b0, 50);
        wait_pin(0, 1'b0, 200);
        check(pins, 3'h0, "down on reset warning");
        warn <= 1'b0;
        end_of_test;
    end
endmodule
